/* File: src/rpg_consts.svh */
// named constants for the regular pulse grid residual codec
// assumes inclusion by bare name from the package and the codec
`ifndef RPG_CONSTS_SVH
`define RPG_CONSTS_SVH

// ==========================================
// segment geometry
`define RPG_SEG_LEN 40
`define RPG_SEG_LAST 6'h27
`define RPG_SUB_LEN 13
`define RPG_SUB_LAST 6'h0C
`define RPG_DECIM 3
`define RPG_GRID_LAST 6'h03
`define RPG_TAPS 11
`define RPG_TAP_MID 5

// ==========================================
// weighting filter taps, scaled by 2^13
`define RPG_H5 16'sh2000
`define RPG_H4 16'sh166D
`define RPG_H3 16'sh0806
`define RPG_H2 16'sh0000
`define RPG_H1 16'shFE8A
`define RPG_H0 16'shFF7A
`define RPG_FILT_SHIFT 13
`define RPG_FILT_RND 32'sh00001000

// ==========================================
// saturation limits
`define RPG_SAT_MAX 32'sh00007FFF
`define RPG_SAT_MIN 32'shFFFF8000

// ==========================================
// peak and sample quantizer
`define RPG_LIN_TOP 16'h01FF
`define RPG_LIN_CODES 6'h10
`define RPG_NORM_SHIFT 15
`define RPG_QSTEP_SHIFT 13
`define RPG_LVL_STEP 32'sh00002000
`define RPG_LVL_BASE 32'shFFFF9000
`define RPG_QNEG_TOP 3'h3
`define RPG_QPOS_BOT 3'h4

// ==========================================
// received word layout in decode mode
`define RPG_RX_GRID_BEAT 0
`define RPG_RX_PEAK_BEAT 1
`define RPG_RX_SAMP_BEAT 2

`endif

/* File: src/rpg_pkg.sv */
// types shared by the regular pulse grid residual codec
// assumes rpg_consts.svh on the include path
package rpg_pkg;
  `include "rpg_consts.svh"

  // ==========================================
  // carriers
  typedef struct packed {
    logic decode;
    logic signed [15:0] resid;
    logic signed [15:0] est;
  } rpg_in_t;

  typedef struct packed {
    logic signed [15:0] lt_resid;
    logic signed [15:0] st_resid;
  } rpg_out_t;

  typedef struct packed {
    logic [1:0] grid;
    logic [5:0] peak;
    logic [12:0][2:0] sample_code;
  } rpg_codes_t;

  // ==========================================
  // sequencer states
  typedef enum logic [2:0] {
    S_LOAD = 3'b000,
    S_FILT = 3'b001,
    S_ENER = 3'b010,
    S_PEAK = 3'b011,
    S_QUANT = 3'b100,
    S_OUT = 3'b101,
    S_DONE = 3'b110
  } rpg_state_t;
endpackage

/* File: src/rpg_fifo.sv */
// small synchronous fifo for the reconstructed residual stream
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module rpg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  // ==========================================
  // pointers
  always_comb begin
    in_ready = (count != CW'(DEPTH));
    out_data = mem[rd_ptr];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      // registered so the stream valid leaves from a flop
      out_valid <= (next_count != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

/* File: src/rpg_codec.sv */
// regular pulse grid residual encoder and decoder, one sub-segment a time
// assumes upstream holds beats until taken and drains codes on the pulse
//
// Function
// (RL1) frames handled as 40-sample sub-segments
// (RL2) short term residual equals residual plus estimate
// (RL3) symmetric 11-tap weighting filter taps
// (RL4) filter keeps 40 central samples, zero padding
// (RL5) decimate by three into four grids
// (RL6) pick grid with largest energy
// (RL7) emit grid index as 2-bit code
// (RL8) peak magnitude encoded as 6-bit code
// (RL9) piecewise logarithmic peak table, upper bounds
// (RL10) normalize by decoded peak, not raw
// (RL11) uniform 3-bit sample quantizer, width 8192
// (RL12) fixed inverse quantizer levels per code
// (RL13) denormalize levels by decoded peak
// (RL14) zero-insertion upsampling onto chosen grid
// (RL15) receiver rebuilds residual with same decoding
// (RL16) 16-bit sums saturate at both limits
// (RL17) receiver keeps only valid code bits
// (RL18) equal energies resolve to lowest grid
// (RL19) valid handshake, completion before next segment
`timescale 1ns/1ps
`include "rpg_consts.svh"
module rpg_codec #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sub-segment input beats
  input wire logic in_valid,
  output logic in_ready,
  input wire rpg_pkg::rpg_in_t in_beat,
  // reconstructed residual stream
  output logic out_valid,
  input wire logic out_ready,
  output rpg_pkg::rpg_out_t out_beat,
  // coded parameters
  output logic codes_valid,
  output rpg_pkg::rpg_codes_t codes,
  output logic seg_done
);
  import rpg_pkg::*;

  // ==========================================
  // arithmetic helpers
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > `RPG_SAT_MAX) begin
      return 16'sh7FFF;
    end else if (v < `RPG_SAT_MIN) begin
      return 16'sh8000;
    end
    return v[15:0];
  endfunction

  function automatic logic [15:0] absv(input logic signed [15:0] v);
    if (v == 16'sh8000) begin
      return 16'h7FFF;
    end
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic signed [15:0] tap(input int i);
    int m;
    m = (i > `RPG_TAP_MID) ? (`RPG_TAPS - 1 - i) : i;
    case (m)
      0: return `RPG_H0;
      1: return `RPG_H1;
      2: return `RPG_H2;
      3: return `RPG_H3;
      4: return `RPG_H4;
      default: return `RPG_H5;
    endcase
  endfunction

  function automatic logic [5:0] peak_enc(input logic [15:0] p);
    logic [5:0] c;
    c = {2'h0, p[8:5]};
    if (p > `RPG_LIN_TOP) begin
      for (int b = 9; b < 15; b++) begin
        if (p[b]) begin
          c = 6'(8 * (b - 7)) | 6'((p >> (b - 3)) & 16'h0007);
        end
      end
    end
    return c;
  endfunction

  function automatic logic [15:0] peak_dec(input logic [5:0] c);
    logic [15:0] v;
    v = {7'h00, c[3:0], 5'h1F};
    if (c >= `RPG_LIN_CODES) begin
      v = 16'((32'(c[2:0]) + 32'd9) << (32'(c[5:3]) + 32'd4)) - 16'h0001;
    end
    return v;
  endfunction

  // ==========================================
  // sequencer state
  rpg_state_t state;
  rpg_state_t next_state;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic dec;
  logic next_dec;
  logic [1:0] grid;
  logic [1:0] next_grid;
  logic [35:0] best;
  logic [35:0] next_best;
  logic [5:0] peak_code;
  logic [5:0] next_peak_code;
  logic [12:0][2:0] scode;
  logic [12:0][2:0] next_scode;
  logic next_in_ready;
  logic next_codes_valid;
  logic next_seg_done;
  rpg_codes_t next_codes;

  logic signed [15:0] resid [0:`RPG_SEG_LEN-1];
  logic signed [15:0] est [0:`RPG_SEG_LEN-1];
  logic signed [15:0] xf [0:`RPG_SEG_LEN-1];
  logic signed [15:0] xm [0:`RPG_SUB_LEN-1];

  logic load_we;
  logic filt_we;
  logic xm_we;
  logic signed [15:0] filt_val;
  logic signed [15:0] xm_val;
  logic signed [31:0] acc;
  logic [35:0] energy;
  logic signed [15:0] cur_x;
  logic [15:0] cur_mag;
  logic [15:0] pk_mag;
  logic [15:0] pk_dec;
  logic [31:0] quo;
  logic [31:0] qstep;
  logic [2:0] qcode;
  logic signed [31:0] lvl;
  logic signed [31:0] prod;
  logic fifo_ready;
  logic push;
  rpg_out_t push_data;
  int j;
  int diff;

  assign pk_dec = peak_dec(peak_code);

  // ==========================================
  // datapath and next state
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_dec = dec;
    next_grid = grid;
    next_best = best;
    next_peak_code = peak_code;
    next_scode = scode;
    next_codes_valid = 1'b0;
    next_seg_done = 1'b0;
    next_codes = codes;
    load_we = 1'b0;
    filt_we = 1'b0;
    xm_we = 1'b0;
    push = 1'b0;
    acc = '0;
    energy = '0;
    pk_mag = '0;
    quo = '0;
    qstep = '0;
    qcode = `RPG_QPOS_BOT;
    lvl = '0;
    prod = '0;
    j = 0;
    diff = 0;
    cur_x = xf[6'(grid) + 6'(`RPG_DECIM * cnt)];
    cur_mag = absv(cur_x);
    push_data = '0;
    case (state)
      S_LOAD: begin
        if (in_valid && in_ready) begin
          load_we = 1'b1; // RL19
          next_cnt = cnt + 6'h01;
          if (cnt == 6'h00) begin
            next_dec = in_beat.decode;
          end
          if (cnt == `RPG_SEG_LAST) begin // RL1
            next_cnt = 6'h00;
            next_state = dec ? S_PEAK : S_FILT;
          end
        end
      end
      S_FILT: begin
        for (int i = 0; i < `RPG_TAPS; i++) begin
          j = int'(cnt) + `RPG_TAP_MID - i;
          if (j >= 0 && j < `RPG_SEG_LEN) begin // RL4
            acc = acc + tap(i) * resid[j]; // RL3
          end
        end
        filt_we = 1'b1;
        next_cnt = cnt + 6'h01;
        if (cnt == `RPG_SEG_LAST) begin
          next_cnt = 6'h00;
          next_state = S_ENER;
        end
      end
      S_ENER: begin
        for (int i = 0; i < `RPG_SUB_LEN; i++) begin
          prod = xf[int'(cnt) + `RPG_DECIM * i] * xf[int'(cnt) + `RPG_DECIM * i]; // RL5
          energy = energy + 36'(unsigned'(prod)); // RL6
        end
        // strict compare keeps the lowest grid on a tie
        if (cnt == 6'h00 || energy > best) begin // RL18
          next_best = energy;
          next_grid = cnt[1:0];
        end
        next_cnt = cnt + 6'h01;
        if (cnt == `RPG_GRID_LAST) begin
          next_cnt = 6'h00;
          next_state = S_PEAK;
        end
      end
      S_PEAK: begin
        if (dec) begin
          next_grid = resid[`RPG_RX_GRID_BEAT][1:0]; // RL17
          next_peak_code = resid[`RPG_RX_PEAK_BEAT][5:0]; // RL17
        end else begin
          for (int i = 0; i < `RPG_SUB_LEN; i++) begin
            if (absv(xf[int'(grid) + `RPG_DECIM * i]) > pk_mag) begin
              pk_mag = absv(xf[int'(grid) + `RPG_DECIM * i]); // RL8
            end
          end
          next_peak_code = peak_enc(pk_mag); // RL9
        end
        next_state = S_QUANT;
      end
      S_QUANT: begin
        // one divide per cycle: 13 cycles traded for a single divider
        quo = (32'(cur_mag) << `RPG_NORM_SHIFT) / 32'(pk_dec); // RL10
        if (cur_x[15]) begin
          qstep = (quo == '0) ? '0 : (quo - 32'h1) >> `RPG_QSTEP_SHIFT;
          qcode = (qstep >= 32'h3) ? 3'h0 : `RPG_QNEG_TOP - qstep[2:0]; // RL11
        end else begin
          qstep = quo >> `RPG_QSTEP_SHIFT;
          qcode = (qstep >= 32'h3) ? 3'h7 : `RPG_QPOS_BOT + qstep[2:0]; // RL11
        end
        if (dec) begin
          qcode = resid[int'(cnt) + `RPG_RX_SAMP_BEAT][2:0]; // RL17
        end
        lvl = `RPG_LVL_BASE + $signed(32'(qcode)) * `RPG_LVL_STEP; // RL12
        prod = (lvl * $signed({16'h0000, pk_dec})) >>> `RPG_NORM_SHIFT; // RL13
        xm_we = 1'b1; // RL15
        next_scode[cnt[3:0]] = qcode;
        next_cnt = cnt + 6'h01;
        if (cnt == `RPG_SUB_LAST) begin
          next_cnt = 6'h00;
          next_state = S_OUT;
        end
      end
      S_OUT: begin
        diff = int'(cnt) - int'(grid);
        if (diff >= 0 && diff % `RPG_DECIM == 0 &&
            diff / `RPG_DECIM < `RPG_SUB_LEN) begin
          push_data.lt_resid = xm[diff / `RPG_DECIM]; // RL14
        end
        push_data.st_resid = sat16(32'(push_data.lt_resid) +
                                   32'(est[cnt])); // RL2 RL16
        push = 1'b1;
        if (fifo_ready) begin
          next_cnt = cnt + 6'h01;
          if (cnt == `RPG_SEG_LAST) begin
            next_cnt = 6'h00;
            next_state = S_DONE;
          end
        end
      end
      S_DONE: begin
        next_codes.grid = grid; // RL7
        next_codes.peak = peak_code;
        next_codes.sample_code = scode;
        next_codes_valid = 1'b1;
        next_seg_done = 1'b1; // RL19
        next_state = S_LOAD;
      end
      default: begin
        next_state = S_LOAD;
        next_cnt = 6'h00;
      end
    endcase
    filt_val = sat16((acc + `RPG_FILT_RND) >>> `RPG_FILT_SHIFT); // RL16
    xm_val = prod[15:0];
    // ready only while loading so no beat lands during processing
    next_in_ready = (next_state == S_LOAD) &&
                    !(state == S_LOAD && next_state != S_LOAD); // RL19
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= S_LOAD;
      cnt <= 6'h00;
      dec <= 1'b0;
      grid <= 2'h0;
      best <= '0;
      peak_code <= 6'h00;
      scode <= '0;
      in_ready <= 1'b0;
      codes_valid <= 1'b0;
      seg_done <= 1'b0;
      codes <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      dec <= next_dec;
      grid <= next_grid;
      best <= next_best;
      peak_code <= next_peak_code;
      scode <= next_scode;
      in_ready <= next_in_ready;
      codes_valid <= next_codes_valid;
      seg_done <= next_seg_done;
      codes <= next_codes;
    end
  end

  // ==========================================
  // sample memories
  always_ff @(posedge clk) begin
    if (load_we) begin
      resid[cnt] <= in_beat.resid;
      est[cnt] <= in_beat.est;
    end
    if (filt_we) begin
      xf[cnt] <= filt_val;
    end
    if (xm_we) begin
      xm[cnt[3:0]] <= xm_val;
    end
  end

  // ==========================================
  // output buffer, stalls the sequencer when full
  rpg_fifo #(
    .WIDTH($bits(rpg_out_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_beat)
  );

  // ==========================================
  // checks
  ready_in_load_a: assert property (@(posedge clk) disable iff (!rst_n) // RL19
    in_ready |-> state == S_LOAD)
    else $error("input ready outside load");

  done_after_out_a: assert property (@(posedge clk) disable iff (!rst_n) // RL19
    (state == S_OUT && cnt == `RPG_SEG_LAST && fifo_ready) |=> ##1 seg_done)
    else $error("segment completion missing");

  filt_span_a: assert property (@(posedge clk) disable iff (!rst_n) // RL4
    (state == S_FILT && cnt == 6'h00) |->
    ##39 (state == S_FILT) ##1 (state == S_ENER))
    else $error("filter span not 40 samples");

  grid_scan_a: assert property (@(posedge clk) disable iff (!rst_n) // RL6
    (state == S_ENER && cnt == 6'h00) |->
    ##3 (state == S_ENER) ##1 (state == S_PEAK))
    else $error("grid scan not four candidates");

  peak_bound_a: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    (state == S_QUANT && !dec) |-> pk_dec >= cur_mag)
    else $error("decoded peak below sample");

  zero_code_a: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    (state == S_QUANT && !dec && cur_x == 16'sh0000) |=>
    scode[$past(cnt[3:0])] == `RPG_QPOS_BOT)
    else $error("zero sample not coded as 4");

  off_grid_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RL14
    (push && (cnt < 6'(grid) || (int'(cnt) - int'(grid)) % `RPG_DECIM != 0))
    |-> push_data.lt_resid == 16'sh0000)
    else $error("off-grid position not zero");

  no_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // RL16
    (push && !push_data.lt_resid[15] && !est[cnt][15]) |->
    !push_data.st_resid[15])
    else $error("saturating add wrapped");

  rx_mask_a: assert property (@(posedge clk) disable iff (!rst_n) // RL17
    (state == S_PEAK && dec) |=>
    grid == $past(resid[`RPG_RX_GRID_BEAT][1:0]))
    else $error("received grid not masked");

  quant_span_a: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    (state == S_QUANT && cnt == 6'h00) |->
    ##12 (state == S_QUANT) ##1 (state == S_OUT))
    else $error("quantizer span not 13 samples");
endmodule

/* File: verification/rpg_far_end.sv */
// far-end model: upstream beat source and downstream drain
// assumes the bench fills seg[] and pulses go for one cycle
`timescale 1ns/1ps
module rpg_far_end (
  // clock and control
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] stall,
  // beats toward the codec
  output logic in_valid,
  input wire logic in_ready,
  output rpg_pkg::rpg_in_t in_beat,
  // rebuilt stream from the codec
  output logic out_ready
);
  import rpg_pkg::*;
  rpg_in_t seg[40];
  int idx = 40;
  logic [31:0] lf = 32'h1234ABCD;

  // ==========================================
  // beat source and drain
  initial begin
    in_valid = 1'b0;
    in_beat = '0;
    out_ready = 1'b0;
  end

  always @(posedge clk) begin
    if (in_valid && in_ready) begin
      idx++;
    end
    if (go) begin
      idx = 0;
    end
    #1;
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    // stall 1 drains at random, 2 holds so the fifo fills
    out_ready = (stall == 2'h0) || (stall == 2'h1 && lf[0]);
    if (idx < 40) begin
      in_valid = 1'b1;
      in_beat = seg[idx];
    end else begin
      in_valid = 1'b0;
      // released lines toggle so a stale value never looks valid
      in_beat = ~in_beat;
    end
  end
endmodule

/* File: verification/rpg_codec_bench.sv */
// self-checking bench for the residual codec
// assumes the far-end model feeds beats and drains the stream
`timescale 1ns/1ps
module rpg_codec_bench;
  import rpg_pkg::*;
  // ==========================================
  // clock, reset and wiring
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic [1:0] stall = 2'h0;
  logic in_valid, in_ready, out_valid, out_ready, codes_valid, seg_done;
  rpg_in_t in_beat;
  rpg_out_t out_beat;
  rpg_codes_t codes;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'hD61A;
  rpg_codes_t cq[$];
  rpg_out_t oq[$];
  int amps[6] = '{4000, 100, 9000, 20, 1500, 32767};

  always #4 clk = ~clk;

  rpg_codec #(.FIFO_DEPTH(4)) u_dut (.clk(clk), .rst_n(rst_n),
    .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat),
    .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat),
    .codes_valid(codes_valid), .codes(codes), .seg_done(seg_done));

  rpg_far_end u_far (.clk(clk), .go(go), .stall(stall),
    .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat),
    .out_ready(out_ready));

  // ==========================================
  // helpers
  task automatic check(input logic [46:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int sat(input int v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction

  // magnitude clipped like a 16-bit abs, so -32768 reads 32767
  function automatic int mag(input int v);
    return v < 0 ? (v < -32767 ? 32767 : -v) : v;
  endfunction

  // upper bound of the peak interval
  function automatic int dec_peak(input int c);
    if (c < 16) return 32 * c + 31;
    return (1 << ((c >> 3) + 7)) + ((c & 7) + 1) * (1 << ((c >> 3) + 4)) - 1;
  endfunction

  function automatic rpg_codes_t encode(input logic [15:0] w[40]);
    int h[11] = '{-134, -374, 0, 2054, 5741, 8192, 5741, 2054, 0, -374, -134};
    int x[40];
    longint en, best;
    int acc, mx, xd, q, j;
    rpg_codes_t c;
    c = '0;
    best = -1;
    mx = 0;
    for (int k = 0; k < 40; k++) begin
      acc = 4096;
      for (int i = 0; i < 11; i++) begin
        j = k + 5 - i;
        if (j >= 0 && j < 40) acc += h[i] * int'($signed(w[j]));
      end
      x[k] = sat(acc >>> 13);
    end
    for (int m = 0; m < 4; m++) begin
      en = 0;
      for (int i = 0; i < 13; i++) en += longint'(x[m + 3 * i]) * x[m + 3 * i];
      // strict compare keeps the lowest grid on ties
      if (en > best) begin
        best = en;
        c.grid = 2'(m);
      end
    end
    for (int i = 0; i < 13; i++) begin
      j = x[c.grid + 3 * i];
      if (mag(j) > mx) mx = mag(j);
    end
    if (mx <= 511) c.peak = 6'(mx >> 5);
    else begin
      j = 15;
      while ((mx >> j) == 0) j--;
      c.peak = 6'(8 * (j - 7) + ((mx >> (j - 3)) & 7));
    end
    xd = dec_peak(c.peak);
    for (int i = 0; i < 13; i++) begin
      j = x[c.grid + 3 * i];
      q = (mag(j) << 15) / xd;
      if (j < 0) c.sample_code[i] = q == 0 ? 3'h3 : 3'(3 - ((q - 1) >> 13));
      else c.sample_code[i] = (q >> 13) >= 3 ? 3'h7 : 3'(4 + (q >> 13));
    end
    return c;
  endfunction

  task automatic expect_out(input rpg_codes_t c, input logic [15:0] est[40]);
    int xd, lt, g, i, q;
    xd = dec_peak(c.peak);
    g = c.grid;
    cq.push_back(c);
    for (int k = 0; k < 40; k++) begin
      lt = 0;
      i = (k - g) / 3;
      if (k >= g && (k - g) % 3 == 0 && i < 13) begin
        q = c.sample_code[i];
        lt = ((-28672 + 8192 * q) * xd) >>> 15;
      end
      oq.push_back({16'(lt), 16'(sat(lt + int'($signed(est[k]))))});
    end
  endtask

  task automatic wait_idle();
    int n = 0;
    while (u_far.idx != 40 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 3000) begin
      n_mismatch++;
      $display("Error at %0t: segment beats never taken", $time);
    end
  endtask

  task automatic run_seg(input bit dec, input int amp);
    logic [15:0] w[40];
    logic [15:0] est[40];
    rpg_codes_t c;
    wait_idle();
    for (int k = 0; k < 40; k++) begin
      w[k] = dec ? rnd() : 16'($signed(rnd()) % amp);
      est[k] = rnd();
    end
    if (dec) begin
      c = 47'({rnd(), rnd()});
      w[0][1:0] = c.grid;
      w[1][5:0] = c.peak;
      for (int i = 0; i < 13; i++) w[i + 2][2:0] = c.sample_code[i];
    end else c = encode(w);
    for (int k = 0; k < 40; k++) u_far.seg[k] = {dec, w[k], est[k]};
    expect_out(c, est);
    @(posedge clk);
    #1 go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================
  // monitors
  always @(posedge clk) begin
    if (rst_n) check(seg_done, codes_valid, "done pulse");
    if (codes_valid === 1'b1) check(codes, cq.pop_front(), "codes");
    if (out_valid === 1'b1 && out_ready === 1'b1)
      check(out_beat, oq.pop_front(), "beat");
  end

  // ==========================================
  // sequence
  initial begin
    int n;
    repeat (16) @(posedge clk);
    check({in_ready, out_valid, codes_valid}, 3'h0, "reset");
    #1 rst_n = 1'b1;
    run_seg(1'b0, 1);
    stall = 2'h2;
    run_seg(1'b0, 4000);
    repeat (150) @(posedge clk);
    #1;
    check(out_valid, 1'b1, "held stream");
    check(in_ready, 1'b0, "stalled segment");
    stall = 2'h0;
    for (int s = 0; s < 14; s++) begin
      stall = 2'(s % 2);
      run_seg(s % 3 == 1, amps[s % 6]);
    end
    n = 0;
    while ((oq.size() != 0 || cq.size() != 0) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(oq.size() + cq.size(), 0, "left over");
    report_and_stop();
  end

  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
